// File: design/dual_dac_serial_load_interface.sv
`timescale 1ns/10ps
// How it works
// - Strobe falling wakes the serial input buffers and arms the shift register.
// - Sixteen falling serial clock edges after strobe low each capture one data bit.
// - Strobe rising before the sixteenth edge aborts; no register changes.
// - Input shift register is sixteen bits, one control and data word.
// - Input buffers power down after a completed write until strobe falls again.
// - While load strobe is low, input registers copy into converter registers.
// - A load pulse updates each channel holding new data, both together.
// - Each control word carries a buffer-select bit for that channel's reference.
// - Converter codes are straight unsigned binary, output proportional to code.
module dual_dac_serial_load_interface #(
   parameter int RES = dual_dac_pkg::DATA_RES
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             link_clock,
   input  wire logic             frame_sync_n,
   input  wire logic             serial_data,
   input  wire logic             load_strobe_n,
   output logic [RES-1:0]        dac_code_a,
   output logic [RES-1:0]        dac_code_b,
   output logic                  ref_buffered_a,
   output logic                  ref_buffered_b,
   output logic                  input_buffers_on,
   output logic                  update_pending_a,
   output logic                  update_pending_b,
   output logic                  word_taken,
   output logic                  frame_aborted
);
   import dual_dac_pkg::*;

   typedef struct packed {
      logic [LOAD_SYNC_W-1:0]  load_sync;
      logic [FRAME_SYNC_W-1:0] frame_sync;
      logic [TOG_SYNC_W-1:0]   tog_sync;
      frame_state_t            state;
      logic [RES-1:0]          in_code_a;
      logic [RES-1:0]          in_code_b;
      logic                    in_buf_a;
      logic                    in_buf_b;
      logic                    new_a;
      logic                    new_b;
      logic [RES-1:0]          dac_a;
      logic [RES-1:0]          dac_b;
      logic                    dac_buf_a;
      logic                    dac_buf_b;
      logic                    buffers_on;
      logic                    taken;
      logic                    aborted;
   } state_t;

   localparam logic [RES-1:0] CODE_ZERO = '0;

   state_t q, d;

   logic [WORD_BITS-1:0] link_word;
   logic                 link_toggle;
   logic                 word_arrived;
   logic                 frame_fell;
   logic                 frame_rose;
   logic                 load_active;
   logic [RES-1:0]       word_code;
   channel_t             word_chan;

   serial_capture capture (
      .link_clock   (link_clock),
      .reset        (reset),
      .frame_sync_n (frame_sync_n),
      .serial_data  (serial_data),
      .word         (link_word),
      .word_toggle  (link_toggle)
   );

   // Edge detectors read only stages past the first flip-flop
   assign word_arrived = q.tog_sync[TOG_SYNC_W-2] ^ q.tog_sync[TOG_SYNC_W-1];
   // Strobe path is one stage longer so a word always lands before its frame end
   assign frame_fell   = ~q.frame_sync[FRAME_SYNC_W-2] & q.frame_sync[FRAME_SYNC_W-1];
   assign frame_rose   = q.frame_sync[FRAME_SYNC_W-2] & ~q.frame_sync[FRAME_SYNC_W-1];
   assign load_active  = ~q.load_sync[LOAD_SYNC_W-1];

   // Link word is stable here: it changes only after another full frame
   assign word_code = link_word[DATA_MSB -: RES];
   assign word_chan = channel_t'(link_word[CHAN_BIT]);

   always_comb begin
      d = q;
      d.load_sync  = {q.load_sync[LOAD_SYNC_W-2:0], load_strobe_n};
      d.frame_sync = {q.frame_sync[FRAME_SYNC_W-2:0], frame_sync_n};
      d.tog_sync   = {q.tog_sync[TOG_SYNC_W-2:0], link_toggle};
      d.taken      = 1'b0;
      d.aborted    = 1'b0;

      // Frame tracking drives the input buffer power
      case (q.state)
         FR_IDLE: begin
            if (frame_fell) begin
               d.state = FR_SHIFT;
            end
         end
         FR_SHIFT: begin
            if (word_arrived) begin
               d.state = FR_DONE;
            end else if (frame_rose) begin
               d.state   = FR_IDLE;
               d.aborted = 1'b1;
            end
         end
         FR_DONE: begin
            if (frame_rose) begin
               d.state = FR_IDLE;
            end
         end
         default: begin
            d.state = FR_IDLE;
         end
      endcase
      d.buffers_on = (d.state == FR_SHIFT);

      // Converter registers follow input registers while load is held low
      if (load_active) begin
         d.dac_a     = q.in_code_a;
         d.dac_b     = q.in_code_b;
         d.dac_buf_a = q.in_buf_a;
         d.dac_buf_b = q.in_buf_b;
         d.new_a     = 1'b0;
         d.new_b     = 1'b0;
      end

      // A word landing during load sets its flag; set wins over the clear
      if (word_arrived) begin
         d.taken = 1'b1;
         if (word_chan == CHAN_A) begin
            d.in_code_a = word_code;
            d.in_buf_a  = link_word[BUF_BIT];
            d.new_a     = 1'b1;
         end else begin
            d.in_code_b = word_code;
            d.in_buf_b  = link_word[BUF_BIT];
            d.new_b     = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         q.load_sync  <= {LOAD_SYNC_W{STROBE_IDLE}};
         q.frame_sync <= {FRAME_SYNC_W{STROBE_IDLE}};
         q.tog_sync   <= '0;
         q.state      <= FR_IDLE;
         q.in_code_a  <= CODE_ZERO;
         q.in_code_b  <= CODE_ZERO;
         q.in_buf_a   <= 1'b0;
         q.in_buf_b   <= 1'b0;
         q.new_a      <= 1'b0;
         q.new_b      <= 1'b0;
         q.dac_a      <= CODE_ZERO;
         q.dac_b      <= CODE_ZERO;
         q.dac_buf_a  <= 1'b0;
         q.dac_buf_b  <= 1'b0;
         q.buffers_on <= 1'b0;
         q.taken      <= 1'b0;
         q.aborted    <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign dac_code_a       = q.dac_a;
   assign dac_code_b       = q.dac_b;
   assign ref_buffered_a   = q.dac_buf_a;
   assign ref_buffered_b   = q.dac_buf_b;
   assign input_buffers_on = q.buffers_on;
   assign update_pending_a = q.new_a;
   assign update_pending_b = q.new_b;
   assign word_taken       = q.taken;
   assign frame_aborted    = q.aborted;

endmodule

// File: design/dual_dac_pkg.sv
package dual_dac_pkg;

   // Serial word
   localparam int WORD_BITS = 16;
   localparam int COUNT_W   = 5;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 5'h00;
   localparam logic [COUNT_W-1:0] COUNT_ONE  = 5'h01;
   localparam logic [COUNT_W-1:0] COUNT_LAST = 5'h0f;
   localparam logic [COUNT_W-1:0] COUNT_FULL = 5'h10;

   // Control word fields, sent most significant bit first
   localparam int CHAN_BIT  = 15;
   localparam int BUF_BIT   = 14;
   localparam int DATA_MSB  = 11;
   localparam int DATA_RES  = 12;

   // Reset values
   localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
   localparam logic               STROBE_IDLE = 1'b1;

   // Synchroniser depths
   localparam int LOAD_SYNC_W  = 2;
   localparam int FRAME_SYNC_W = 4;
   localparam int TOG_SYNC_W   = 3;

   // Timing
   localparam int CLOCK_HZ     = 20_000_000;
   localparam int LINK_MAX_HZ  = 30_000_000;
   localparam int LINK_MIN_CYCLE_NS = 33;

   typedef enum logic {
      CHAN_A = 1'b0,
      CHAN_B = 1'b1
   } channel_t;

   typedef enum logic [2:0] {
      FR_IDLE  = 3'h1,
      FR_SHIFT = 3'h2,
      FR_DONE  = 3'h4
   } frame_state_t;

endpackage

// File: design/serial_capture.sv
`timescale 1ns/10ps
module serial_capture (
   input  wire logic                            link_clock,
   input  wire logic                            reset,
   input  wire logic                            frame_sync_n,
   input  wire logic                            serial_data,
   output logic [dual_dac_pkg::WORD_BITS-1:0]   word,
   output logic                                 word_toggle
);
   import dual_dac_pkg::*;

   // Shift state dies with the frame; the hand-off word must survive it
   typedef struct packed {
      logic [WORD_BITS-1:0] shift;
      logic [COUNT_W-1:0]   count;
   } shift_t;

   typedef struct packed {
      logic [WORD_BITS-1:0] word;
      logic                 toggle;
   } hand_t;

   shift_t sh_q, sh_d;
   hand_t  hd_q, hd_d;
   logic   frame_clear;

   // Strobe high clears the frame at once, since the serial clock may stand still
   assign frame_clear = frame_sync_n | reset;

   always_comb begin
      sh_d = sh_q;
      hd_d = hd_q;
      if (sh_q.count != COUNT_FULL) begin
         sh_d.shift = {sh_q.shift[WORD_BITS-2:0], serial_data};
         sh_d.count = sh_q.count + COUNT_ONE;
         if (sh_q.count == COUNT_LAST) begin
            hd_d.word   = {sh_q.shift[WORD_BITS-2:0], serial_data};
            hd_d.toggle = ~hd_q.toggle;
         end
      end
   end

   // Falling edge of the serial clock is the capture edge
   always_ff @(negedge link_clock or posedge frame_clear) begin
      if (frame_clear) begin
         sh_q <= '{shift: WORD_RESET, count: COUNT_ZERO};
      end else begin
         sh_q <= sh_d;
      end
   end

   always_ff @(negedge link_clock or posedge reset) begin
      if (reset) begin
         hd_q <= '{word: WORD_RESET, toggle: 1'b0};
      end else begin
         hd_q <= hd_d;
      end
   end

   assign word        = hd_q.word;
   assign word_toggle = hd_q.toggle;

endmodule

// File: verification/dual_dac_assertions.sv
`timescale 1ns/10ps
module dual_dac_assertions #(
   parameter int RES = 12
) (
   input wire logic           clock,
   input wire logic           reset,
   input wire logic           frame_sync_n,
   input wire logic           load_strobe_n,
   input wire logic [RES-1:0] dac_code_a,
   input wire logic [RES-1:0] dac_code_b,
   input wire logic           input_buffers_on,
   input wire logic           update_pending_a,
   input wire logic           update_pending_b,
   input wire logic           word_taken,
   input wire logic           frame_aborted
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   AST_TAKEN_PULSE: assert property (word_taken |=> !word_taken) else $error("word taken held");
   AST_ABORT_PULSE: assert property (frame_aborted |=> !frame_aborted) else $error("abort held");
   AST_ABORT_ALONE: assert property (frame_aborted |-> !word_taken) else $error("abort with word");
   AST_TAKEN_SETS: assert property (word_taken |-> update_pending_a || update_pending_b)
      else $error("word without pending");
   AST_DONE_OFF: assert property (word_taken |-> !input_buffers_on) else $error("buffers on after word");
   AST_IDLE_OFF: assert property (frame_sync_n [*8] |-> !input_buffers_on) else $error("buffers on idle");
   AST_WAKE: assert property ($fell(frame_sync_n) ##1 !frame_sync_n [*6] |-> input_buffers_on)
      else $error("buffers not woken");
   // Four quiet samples cover the synchroniser delay before a hold is expected
   AST_HOLD: assert property ($past(load_strobe_n) && $past(load_strobe_n, 2) && $past(load_strobe_n, 3)
      && $past(load_strobe_n, 4) |-> $stable(dac_code_a) && $stable(dac_code_b)) else $error("code moved");
   AST_LOAD_CLEARS: assert property (!$past(load_strobe_n, 2) && !$past(load_strobe_n, 3)
      && !$past(load_strobe_n, 4) && !$past(load_strobe_n, 5) && !word_taken
      |-> !update_pending_a && !update_pending_b) else $error("pending kept");
   cover property (word_taken);
   cover property (frame_aborted);
   cover property (!load_strobe_n && update_pending_b);
endmodule
bind dual_dac_serial_load_interface dual_dac_assertions #(.RES(RES)) checker_inst (.clock(clock), .reset(reset),
   .frame_sync_n(frame_sync_n), .load_strobe_n(load_strobe_n), .dac_code_a(dac_code_a), .dac_code_b(dac_code_b),
   .input_buffers_on(input_buffers_on), .update_pending_a(update_pending_a), .update_pending_b(update_pending_b),
   .word_taken(word_taken), .frame_aborted(frame_aborted));

// File: verification/host_model.sv
`timescale 1ns/10ps
module host_model (
   output logic frame_sync_n,
   output logic link_clock,
   output logic serial_data
);
   initial begin
      frame_sync_n = 1'b1;
      link_clock = 1'b1;
      serial_data = 1'b0;
   end
   // Clock idles high and stands still between frames; a 48 ns period stays under the ceiling
   task automatic send(input logic [15:0] w, input int n, input int extra);
      frame_sync_n = 1'b0;
      #24;
      for (int i = 0; i < n + extra; i++) begin
         serial_data = (i < 16) ? w[15-i] : ~serial_data;
         #12 link_clock = 1'b0;
         #24 link_clock = 1'b1;
         #12;
      end
      serial_data = ~serial_data;
      #12 frame_sync_n = 1'b1;
      #300;
   endtask
endmodule

// File: verification/dual_dac_serial_load_interface_bench.sv
`timescale 1ns/10ps
module dual_dac_serial_load_interface_bench;
   import dual_dac_pkg::*;
   logic        clock, reset, load_strobe_n, frame_sync_n, link_clock, serial_data;
   logic [11:0] dac_code_a, dac_code_b;
   logic        ref_buffered_a, ref_buffered_b, input_buffers_on;
   logic        update_pending_a, update_pending_b, word_taken, frame_aborted;
   int          miscompares = 0, samples_checked = 0, words = 0, aborts = 0, wexp = 0, aexp = 0;
   int          exp_code[2] = '{0, 0}, exp_buf[2] = '{0, 0}, exp_pend[2] = '{0, 0};
   int          in_code[2] = '{0, 0}, in_buf[2] = '{0, 0};
   int          chan_q[$];
   dual_dac_serial_load_interface dut (.clock(clock), .reset(reset), .link_clock(link_clock),
      .frame_sync_n(frame_sync_n), .serial_data(serial_data), .load_strobe_n(load_strobe_n),
      .dac_code_a(dac_code_a), .dac_code_b(dac_code_b), .ref_buffered_a(ref_buffered_a),
      .ref_buffered_b(ref_buffered_b), .input_buffers_on(input_buffers_on), .update_pending_a(update_pending_a),
      .update_pending_b(update_pending_b), .word_taken(word_taken), .frame_aborted(frame_aborted));
   host_model host (.frame_sync_n(frame_sync_n), .link_clock(link_clock), .serial_data(serial_data));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Pulses are read mid-cycle, well away from the edge that launches them
   always @(negedge clock) begin
      if (word_taken === 1'b1) begin
         words++;
         if (chan_q.size() == 0) check("word_taken", 16'h0001, 16'h0000);
         else if (chan_q.pop_front() == 0) check("update_pending_a", update_pending_a, 16'h0001);
         else check("update_pending_b", update_pending_b, 16'h0001);
      end
      if (frame_aborted === 1'b1) aborts++;
   end
   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic check_all();
      check("dac_code_a", dac_code_a, exp_code[0]);
      check("dac_code_b", dac_code_b, exp_code[1]);
      check("ref_buffered_a", ref_buffered_a, exp_buf[0]);
      check("ref_buffered_b", ref_buffered_b, exp_buf[1]);
      check("update_pending_a", update_pending_a, exp_pend[0]);
      check("update_pending_b", update_pending_b, exp_pend[1]);
      check("input_buffers_on", input_buffers_on, 16'h0000);
   endtask
   task automatic copy();
      for (int c = 0; c < 2; c++) begin
         exp_code[c] = in_code[c];
         exp_buf[c] = in_buf[c];
         exp_pend[c] = 0;
      end
   endtask
   task automatic write(input logic [15:0] v, input int n, input int extra);
      if (n == 16) chan_q.push_back(v[15]);
      host.send(v, n, extra);
      if (n == 16) begin
         in_code[v[15]] = v[11:0];
         in_buf[v[15]] = v[14];
         exp_pend[v[15]] = 1;
         wexp++;
      end else aexp++;
      if (load_strobe_n === 1'b0) copy();
      for (int i = 0; i < 200 && (words != wexp || aborts != aexp); i++) @(posedge clock);
      check("events", {words[7:0], aborts[7:0]}, {wexp[7:0], aexp[7:0]});
      if (words != wexp || aborts != aexp) close_out();
      repeat (8) @(posedge clock);
      #2 check_all();
   endtask
   initial begin
      reset = 1'b1;
      load_strobe_n = 1'b1;
      void'($urandom(8));
      repeat (20) @(posedge clock);
      #2 reset = 1'b0;
      repeat (2) @(posedge clock);
      #2 check_all();
      for (int i = 0; i < 4; i++) write({i[0], 15'($urandom)}, 16, 0);
      $display("test writes held done");
      @(posedge clock);
      #2 load_strobe_n = 1'b0;
      repeat (4) @(posedge clock);
      #2 load_strobe_n = 1'b1;
      copy();
      repeat (6) @(posedge clock);
      #2 check_all();
      $display("test load pulse done");
      write(16'hcfff, 16, 4);
      write(16'h4abc, 7, 0);
      $display("test extra edges and abort done");
      @(posedge clock);
      #2 load_strobe_n = 1'b0;
      write({1'b0, 15'($urandom)}, 16, 0);
      write({1'b1, 15'($urandom)}, 16, 0);
      $display("test transparent load done");
      close_out();
   end
endmodule
